/* hw/swdpe_sequencer.sv */
`default_nettype none
module swdpe_sequencer #(
	parameter int HALF_CYC = 8,
	parameter int RST_HOLD_CYC = 400,
	parameter int RST_REL_CYC = 4000,
	parameter int PWR_OFF_CYC = 40000,
	parameter int PWR_ON_CYC = 40000,
	parameter int LR_HIGH_BITS = swdpe_pkg::LINE_RESET_HIGH_MIN,
	parameter int LR_LOW_BITS = 2,
	parameter int TAIL_BITS = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// user side: session control
	input wire logic start_i,
	input wire logic mode_i,
	input wire logic no_reset_pin_i,
	input wire logic step_fail_i,
	// user side: one link transaction
	input wire logic req_valid_i,
	input wire logic req_apndp_i,
	input wire logic req_rnw_i,
	input wire logic [1:0] req_addr_i,
	input wire logic [31:0] req_wdata_i,
	input wire logic req_optional_i,
	output logic ready_o,
	output logic busy_o,
	output logic aborted_o,
	output logic rsp_valid_o,
	output logic rsp_ok_o,
	output logic [2:0] rsp_ack_o,
	output logic [31:0] rsp_rdata_o,
	// target pins
	output logic swdclk_o,
	output logic swdio_o,
	output logic swdio_oe_o,
	input wire logic swdio_i,
	output logic external_reset_low_n_o,
	output logic power_en_o
);
	import swdpe_pkg::*;

	localparam int BIT_CYC = 2 * HALF_CYC;
	localparam logic [PHASE_W-1:0] PH_LAST = PHASE_W'(BIT_CYC - 1);
	localparam logic [PHASE_W-1:0] PH_SAMPLE = PHASE_W'(HALF_CYC - 1);
	localparam logic [PHASE_W-1:0] PH_HIGH = PHASE_W'(HALF_CYC);

	typedef struct packed {
		swdpe_state_e st;
		logic [PHASE_W-1:0] phase;
		logic [CNT_W-1:0] cnt;
		logic [DATA_PAR_BITS-1:0] shreg;
		logic [DATA_PAR_BITS-1:0] rd;
		logic [2:0] ack;
		logic rnw;
		logic optional;
		logic [2:0] sync;
		logic din;
		logic clk;
		logic dio;
		logic oe;
		logic rst_n;
		logic pwr;
		logic ready;
		logic busy;
		logic aborted;
		logic rsp_valid;
		logic rsp_ok;
		logic [2:0] rsp_ack;
		logic [31:0] rsp_rdata;
	} swdpe_state_s;

	swdpe_state_s cur_r;
	swdpe_state_s cur_nxt;

	function automatic logic swdpe_par32(input logic [31:0] d);
		swdpe_par32 = ^d;
	endfunction : swdpe_par32

	function automatic logic [REQ_BITS-1:0] swdpe_req_byte(input logic apndp, input logic rnw,
		input logic [1:0] a);
		// sent lsb first: start, apndp, rnw, a2, a3, parity, stop, park
		swdpe_req_byte = {REQ_PARK, REQ_STOP, apndp ^ rnw ^ a[0] ^ a[1], a[1], a[0], rnw,
			apndp, REQ_START};
	endfunction : swdpe_req_byte

	logic bit_end;
	logic sample;
	logic cnt_zero;
	logic ack_ok;
	logic par_ok;
	logic txn_ok;

	assign bit_end = (cur_r.phase == PH_LAST);
	assign sample = (cur_r.phase == PH_SAMPLE);
	assign cnt_zero = (cur_r.cnt == '0);
	assign ack_ok = (cur_r.ack == ACK_OK);
	assign par_ok = (swdpe_par32(cur_r.rd[DATA_BITS-1:0]) == cur_r.rd[DATA_BITS]);
	assign txn_ok = ack_ok && (!cur_r.rnw || par_ok);

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		cur_nxt = cur_r;
		cur_nxt.rsp_valid = 1'b0;
		// link clock comes from a divider; host bits change while it is low
		cur_nxt.phase = bit_end ? '0 : cur_r.phase + PHASE_W'(1);
		cur_nxt.clk = (cur_nxt.phase >= PH_HIGH);
		// three-stage input; a change counts only once the last two agree
		cur_nxt.sync = {cur_r.sync[1:0], swdio_i};
		if (cur_r.sync[2] == cur_r.sync[1])
		begin
			cur_nxt.din = cur_r.sync[2];
		end
		if (!cnt_zero && (cur_r.st == ST_PWR_OFF || cur_r.st == ST_RST_LOW
			|| cur_r.st == ST_SETTLE))
		begin
			cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
		end
		unique case (cur_r.st)
			ST_IDLE:
			begin
				if (start_i)
				begin
					cur_nxt.aborted = 1'b0;
					cur_nxt.busy = 1'b1;
					if (mode_i == MODE_POWER || no_reset_pin_i)
					begin
						cur_nxt.pwr = 1'b0;
						cur_nxt.cnt = CNT_W'(PWR_OFF_CYC - 1);
						cur_nxt.st = ST_PWR_OFF;
					end
					else
					begin
						cur_nxt.pwr = 1'b1;
						cur_nxt.rst_n = 1'b0;
						cur_nxt.cnt = CNT_W'(RST_HOLD_CYC - 1);
						cur_nxt.st = ST_RST_LOW;
					end
				end
			end
			ST_PWR_OFF:
			begin
				if (cnt_zero)
				begin
					cur_nxt.pwr = 1'b1;
					cur_nxt.cnt = CNT_W'(PWR_ON_CYC - 1);
					cur_nxt.st = ST_SETTLE;
				end
			end
			ST_RST_LOW:
			begin
				if (cnt_zero)
				begin
					cur_nxt.rst_n = 1'b1;
					cur_nxt.cnt = CNT_W'(RST_REL_CYC - 1);
					cur_nxt.st = ST_SETTLE;
				end
			end
			ST_SETTLE:
			begin
				// both methods join here, so all later traffic is common
				if (cnt_zero && bit_end)
				begin
					cur_nxt.dio = 1'b1;
					cur_nxt.oe = 1'b1;
					cur_nxt.cnt = CNT_W'(LR_HIGH_BITS - 1);
					cur_nxt.st = ST_LR_HIGH;
				end
			end
			ST_LR_HIGH:
			begin
				if (bit_end)
				begin
					if (cnt_zero)
					begin
						cur_nxt.dio = 1'b0;
						cur_nxt.cnt = CNT_W'(LR_LOW_BITS - 1);
						cur_nxt.st = ST_LR_LOW;
					end
					else
					begin
						cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
					end
				end
			end
			ST_LR_LOW:
			begin
				if (bit_end)
				begin
					if (cnt_zero)
					begin
						cur_nxt.ready = 1'b1;
						cur_nxt.st = ST_READY;
					end
					else
					begin
						cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
					end
				end
			end
			ST_READY:
			begin
				if (req_valid_i)
				begin
					cur_nxt.ready = 1'b0;
					cur_nxt.rnw = req_rnw_i;
					cur_nxt.optional = req_optional_i;
					cur_nxt.shreg = {swdpe_par32(req_wdata_i), req_wdata_i};
					cur_nxt.rd = {{(DATA_PAR_BITS - REQ_BITS){1'b0}},
						swdpe_req_byte(req_apndp_i, req_rnw_i, req_addr_i)};
					cur_nxt.st = ST_ARM;
				end
			end
			ST_ARM:
			begin
				// request byte waits in rd, write data in shreg
				if (bit_end)
				begin
					cur_nxt.dio = cur_r.rd[0];
					cur_nxt.rd = cur_r.rd >> 1;
					cur_nxt.cnt = CNT_W'(REQ_BITS - 1);
					cur_nxt.st = ST_REQ;
				end
			end
			ST_REQ:
			begin
				if (bit_end)
				begin
					if (cnt_zero)
					begin
						cur_nxt.oe = 1'b0;
						cur_nxt.st = ST_TRN1;
					end
					else
					begin
						cur_nxt.dio = cur_r.rd[0];
						cur_nxt.rd = cur_r.rd >> 1;
						cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
					end
				end
			end
			ST_TRN1:
			begin
				if (bit_end)
				begin
					cur_nxt.cnt = CNT_W'(ACK_BITS - 1);
					cur_nxt.st = ST_ACK;
				end
			end
			ST_ACK:
			begin
				if (sample)
				begin
					cur_nxt.ack = {cur_r.din, cur_r.ack[2:1]};
				end
				if (bit_end)
				begin
					if (!cnt_zero)
					begin
						cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
					end
					else if (ack_ok && cur_r.rnw)
					begin
						cur_nxt.cnt = CNT_W'(DATA_PAR_BITS - 1);
						cur_nxt.st = ST_RDATA;
					end
					else
					begin
						cur_nxt.st = ST_TRN2;
					end
				end
			end
			ST_RDATA:
			begin
				if (sample)
				begin
					cur_nxt.rd = {cur_r.din, cur_r.rd[DATA_PAR_BITS-1:1]};
				end
				if (bit_end)
				begin
					if (cnt_zero)
					begin
						cur_nxt.st = ST_TRN2;
					end
					else
					begin
						cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
					end
				end
			end
			ST_TRN2:
			begin
				// host takes the line back after the turnaround slot
				if (bit_end)
				begin
					cur_nxt.oe = 1'b1;
					if (ack_ok && !cur_r.rnw)
					begin
						cur_nxt.dio = cur_r.shreg[0];
						cur_nxt.shreg = cur_r.shreg >> 1;
						cur_nxt.cnt = CNT_W'(DATA_PAR_BITS - 1);
						cur_nxt.st = ST_WDATA;
					end
					else
					begin
						cur_nxt.dio = 1'b0;
						cur_nxt.cnt = CNT_W'(TAIL_BITS - 1);
						cur_nxt.st = ST_TAIL;
					end
				end
			end
			ST_WDATA:
			begin
				if (bit_end)
				begin
					if (cnt_zero)
					begin
						cur_nxt.dio = 1'b0;
						cur_nxt.cnt = CNT_W'(TAIL_BITS - 1);
						cur_nxt.st = ST_TAIL;
					end
					else
					begin
						cur_nxt.dio = cur_r.shreg[0];
						cur_nxt.shreg = cur_r.shreg >> 1;
						cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
					end
				end
			end
			ST_TAIL:
			begin
				if (bit_end)
				begin
					if (!cnt_zero)
					begin
						cur_nxt.cnt = cur_r.cnt - CNT_W'(1);
					end
					else
					begin
						cur_nxt.rsp_valid = 1'b1;
						cur_nxt.rsp_ok = txn_ok;
						cur_nxt.rsp_ack = (ack_ok && !txn_ok) ? ACK_FAIL : cur_r.ack;
						cur_nxt.rsp_rdata = cur_r.rd[DATA_BITS-1:0];
						if (!txn_ok && !cur_r.optional)
						begin
							cur_nxt.aborted = 1'b1;
							cur_nxt.busy = 1'b0;
							cur_nxt.st = ST_IDLE;
						end
						else
						begin
							cur_nxt.ready = 1'b1;
							cur_nxt.st = ST_READY;
						end
					end
				end
			end
		endcase
		// a failed step from the user halts the flow from any active state
		if (step_fail_i && cur_r.st != ST_IDLE)
		begin
			cur_nxt.aborted = 1'b1;
			cur_nxt.busy = 1'b0;
			cur_nxt.ready = 1'b0;
			cur_nxt.rst_n = 1'b1;
			cur_nxt.dio = 1'b0;
			cur_nxt.oe = 1'b1;
			cur_nxt.st = ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cur_r <= '0;
			cur_r.st <= ST_IDLE;
			cur_r.rst_n <= 1'b1;
			cur_r.oe <= 1'b1;
		end
		else
		begin
			cur_r <= cur_nxt;
		end
	end

	assign ready_o = cur_r.ready;
	assign busy_o = cur_r.busy;
	assign aborted_o = cur_r.aborted;
	assign rsp_valid_o = cur_r.rsp_valid;
	assign rsp_ok_o = cur_r.rsp_ok;
	assign rsp_ack_o = cur_r.rsp_ack;
	assign rsp_rdata_o = cur_r.rsp_rdata;
	assign swdclk_o = cur_r.clk;
	assign swdio_o = cur_r.dio;
	assign swdio_oe_o = cur_r.oe;
	assign external_reset_low_n_o = cur_r.rst_n;
	assign power_en_o = cur_r.pwr;
endmodule : swdpe_sequencer
`default_nettype wire

/* hw/swdpe_pkg.sv */
`default_nettype none
package swdpe_pkg;
	// programming entry method chosen at start
	localparam logic MODE_RESET = 1'b0;
	localparam logic MODE_POWER = 1'b1;
	// three-bit acknowledge codes, sent least significant bit first
	localparam logic [2:0] ACK_OK = 3'h1;
	localparam logic [2:0] ACK_FAIL = 3'h7;
	// request packet framing bits
	localparam logic REQ_START = 1'b1;
	localparam logic REQ_STOP = 1'b0;
	localparam logic REQ_PARK = 1'b1;
	localparam int REQ_BITS = 8;
	localparam int ACK_BITS = 3;
	localparam int DATA_BITS = 32;
	localparam int DATA_PAR_BITS = DATA_BITS + 1;
	// minimum run of high bits in the line reset
	localparam int LINE_RESET_HIGH_MIN = 50;
	localparam int LINE_RESET_LOW_MIN = 1;
	localparam int CNT_W = 24;
	localparam int PHASE_W = 8;

	typedef enum logic [4:0] {
		ST_IDLE,
		ST_PWR_OFF,
		ST_RST_LOW,
		ST_SETTLE,
		ST_LR_HIGH,
		ST_LR_LOW,
		ST_READY,
		ST_ARM,
		ST_REQ,
		ST_TRN1,
		ST_ACK,
		ST_RDATA,
		ST_TRN2,
		ST_WDATA,
		ST_TAIL
	} swdpe_state_e;
endpackage : swdpe_pkg
`default_nettype wire

/* test/swdpe_properties.sv */
`default_nettype none
module swdpe_properties
	import swdpe_pkg::*;
#(
	parameter int HALF_CYC = 8
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic step_fail_i,
	input wire logic ready_o,
	input wire logic busy_o,
	input wire logic aborted_o,
	input wire logic rsp_valid_o,
	input wire logic rsp_ok_o,
	input wire logic [2:0] rsp_ack_o,
	input wire logic swdclk_o,
	input wire logic swdio_o,
	input wire logic swdio_oe_o,
	input wire logic external_reset_low_n_o,
	input wire logic power_en_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] hi_r;
	logic lr_r;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////
	// run of driven ones; lr_r keeps a full line reset until ready
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hi_r <= 10'h000;
			lr_r <= 1'b0;
		end
		else
		begin
			hi_r <= (swdio_oe_o && swdio_o) ? hi_r + {9'h000, hi_r != 10'h3FF} : 10'h000;
			lr_r <= !ready_o && (lr_r || hi_r >= 10'(LINE_RESET_HIGH_MIN * 2 * HALF_CYC));
		end
	end
	////////////////////////////////
	AST_RDY_PINS: assert property (ready_o |->
		power_en_o && external_reset_low_n_o) else $error("ready with target off");
	AST_RST_HELD: assert property (!external_reset_low_n_o |->
		power_en_o && busy_o && !ready_o) else $error("reset outside entry");
	// width follows the hold count of 8 that the bench sets
	AST_RST_PULSE: assert property ($fell(external_reset_low_n_o) |->
		!external_reset_low_n_o[*8] ##[1:2] external_reset_low_n_o) else $error("bad pulse");
	AST_ABORT: assert property (step_fail_i && busy_o |=>
		aborted_o && !busy_o && !ready_o) else $error("no abort");
	AST_TRN_REL: assert property ($fell(swdio_oe_o) |->
		!swdclk_o ##1 !swdio_oe_o[*8]) else $error("line not released");
	AST_OK_ACK: assert property (rsp_valid_o && rsp_ok_o |->
		rsp_ack_o == ACK_OK && ready_o ##1 !rsp_valid_o) else $error("bad ok");
	AST_END_STATE: assert property (rsp_valid_o |->
		ready_o != aborted_o) else $error("bad end state");
	AST_LINE_RST: assert property ($rose(ready_o) && !rsp_valid_o |-> lr_r)
		else $error("ready without line reset");
	AST_COV_OK: cover property (rsp_valid_o && rsp_ok_o);
	AST_COV_OPT: cover property (rsp_valid_o && !rsp_ok_o && ready_o);
	AST_COV_ABORT: cover property ($rose(aborted_o));
endmodule : swdpe_properties
`default_nettype wire

/* test/swdpe_tgt_model.sv */
`default_nettype none
module swdpe_tgt_model
	import swdpe_pkg::*;
(
	input wire logic swdclk_i,
	input wire logic dio_i,
	input wire logic rst_low_n_i,
	input wire logic pwr_i,
	input wire logic [2:0] ack_i,
	input wire logic bad_par_i,
	output logic do_o,
	output logic oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [8];
	logic [7:0] rq;
	logic [32:0] wd;
	logic [2:0] a;
	logic armed;
	int ones;
	////////////////////////////////
	task automatic respond;
		logic [35:0] sh;
		sh = {^mem[a] ^ bad_par_i, mem[a], ack_i};
		@(posedge swdclk_i);
		oe_o = 1'b1;
		for (int i = 0; i < 36; i++)
		begin
			do_o = sh[i];
			@(posedge swdclk_i);
			if (i == 2 && (ack_i != ACK_OK || !rq[2])) break;
		end
		oe_o = 1'b0;
		if (ack_i == ACK_OK && !rq[2])
		begin
			@(posedge swdclk_i);
			for (int i = 0; i < DATA_PAR_BITS; i++)
			begin
				@(posedge swdclk_i);
				wd[i] = dio_i;
			end
			if (!(^wd)) mem[a] = wd[31:0];
		end
	endtask : respond
	////////////////////////////////
	initial
	begin
		do_o = 1'b0;
		oe_o = 1'b0;
		armed = 1'b0;
		ones = 0;
		forever
		begin
			@(posedge swdclk_i);
			rq[0] = dio_i;
			if (!rst_low_n_i || !pwr_i)
			begin
				armed = 1'b0;
				ones = 0;
			end
			else if (!armed)
			begin
				armed = !dio_i && ones >= LINE_RESET_HIGH_MIN;
				ones = dio_i ? ones + 1 : 0;
			end
			else if (dio_i)
			begin
				for (int i = 1; i < REQ_BITS; i++)
				begin
					@(posedge swdclk_i);
					rq[i] = dio_i;
				end
				a = {rq[1], rq[4:3]};
				// a broken packet gets no answer and needs a new line reset
				armed = (^rq[5:1]) == 1'b0 && rq[7:6] == 2'b10;
				if (armed) respond();
			end
		end
	end
endmodule : swdpe_tgt_model
`default_nettype wire

/* test/tb.sv */
`default_nettype none
bind swdpe_sequencer swdpe_properties #(.HALF_CYC(HALF_CYC)) i_chk (.sys_clk_i, .rst_n_i,
	.step_fail_i, .ready_o, .busy_o, .aborted_o, .rsp_valid_o, .rsp_ok_o, .rsp_ack_o,
	.swdclk_o, .swdio_o, .swdio_oe_o, .external_reset_low_n_o, .power_en_o);
////////////////////////////////
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import swdpe_pkg::*;
	logic clk = 1'b0;
	logic rst_n, start, mode, nopin, fail, rv, apndp, rnw, opt, t_bad, t_do, t_oe;
	logic ready, busy, abrt, rsp_v, ok, sclk, sdo, soe, xrst_n, pwr;
	logic [1:0] addr;
	logic [2:0] ack, t_ack;
	logic [31:0] wdata, rd;
	wire logic dio;
	int err_total, checks, lo, po;
	// a released line must not echo the last bit
	assign dio = soe ? sdo : (t_oe ? t_do : ~sdo);
	always #12.5 clk = ~clk;
	swdpe_sequencer #(.HALF_CYC(4), .RST_HOLD_CYC(8), .RST_REL_CYC(8), .PWR_OFF_CYC(8),
		.PWR_ON_CYC(8)) i_dut (
		.sys_clk_i(clk), .rst_n_i(rst_n), .start_i(start), .mode_i(mode),
		.no_reset_pin_i(nopin), .step_fail_i(fail), .req_valid_i(rv), .req_apndp_i(apndp),
		.req_rnw_i(rnw), .req_addr_i(addr), .req_wdata_i(wdata), .req_optional_i(opt),
		.ready_o(ready), .busy_o(busy), .aborted_o(abrt), .rsp_valid_o(rsp_v),
		.rsp_ok_o(ok), .rsp_ack_o(ack), .rsp_rdata_o(rd), .swdclk_o(sclk), .swdio_o(sdo),
		.swdio_oe_o(soe), .swdio_i(dio), .external_reset_low_n_o(xrst_n), .power_en_o(pwr));
	swdpe_tgt_model i_tgt (.swdclk_i(sclk), .dio_i(dio), .rst_low_n_i(xrst_n), .pwr_i(pwr),
		.ack_i(t_ack), .bad_par_i(t_bad), .do_o(t_do), .oe_o(t_oe));
	////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_bit(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask : cmp_bit
	// whenever the target drives the data line the host must have let go of it
	always @(negedge clk)
	begin
		if (t_oe === 1'b1)
		begin
			cmp_bit(soe, 1'b0);
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic entry(input logic m, input logic np);
		lo = 0;
		po = 0;
		@(negedge clk);
		{start, mode, nopin} = {1'b1, m, np};
		@(negedge clk);
		start = 1'b0;
		// count from the first negedge after the start edge, end point excluded
		for (int n = 0; n < 3000 && ready !== 1'b1; n++)
		begin
			lo += int'(!xrst_n);
			po += int'(!pwr);
			@(negedge clk);
		end
		cmp_bit(ready, 1'b1);
	endtask : entry
	// r is {ap/dp select, read, address}
	task automatic txn(input logic [3:0] r, input logic [31:0] d, input logic [2:0] ak,
		input logic bp, input logic op);
		{t_ack, t_bad} = {ak, bp};
		@(negedge clk);
		{apndp, rnw, addr, wdata, opt, rv} = {r, d, op, 1'b1};
		@(negedge clk);
		rv = 1'b0;
		for (int n = 0; n < 2000 && rsp_v !== 1'b1; n++)
			@(negedge clk);
	endtask : txn
	task automatic rsp(input logic k, input logic [2:0] a, input logic r);
		cmp_bit(rsp_v, 1'b1);
		cmp_bit(ok, k);
		cmp({29'h0, ack}, {29'h0, a});
		cmp_bit(ready, r);
		cmp_bit(abrt, !r);
	endtask : rsp
	////////////////////////////////
	task automatic t_traffic;
		txn(4'h9, 32'h2000_0000, ACK_OK, 1'b0, 1'b0);
		rsp(1'b1, ACK_OK, 1'b1);
		txn(4'hB, 32'h1234_5678, ACK_OK, 1'b0, 1'b0);
		rsp(1'b1, ACK_OK, 1'b1);
		txn(4'hF, 32'h0000_0000, ACK_OK, 1'b0, 1'b0);
		rsp(1'b1, ACK_OK, 1'b1);
		cmp(rd, 32'h1234_5678);
		txn(4'hD, 32'h0000_0000, ACK_OK, 1'b0, 1'b0);
		rsp(1'b1, ACK_OK, 1'b1);
		cmp(rd, 32'h2000_0000);
	endtask : t_traffic
	task automatic t_fail_codes;
		txn(4'hF, 32'h0000_0000, ACK_OK, 1'b1, 1'b1);
		rsp(1'b0, ACK_FAIL, 1'b1);
		txn(4'hB, 32'h0000_0005, 3'h2, 1'b0, 1'b1);
		rsp(1'b0, 3'h2, 1'b1);
		txn(4'hF, 32'h0000_0000, 3'h4, 1'b0, 1'b0);
		rsp(1'b0, 3'h4, 1'b0);
		cmp_bit(busy, 1'b0);
	endtask : t_fail_codes
	task automatic t_power_entry;
		entry(MODE_POWER, 1'b0);
		cmp(lo, 32'h0);
		cmp(po, 32'h8);
		cmp_bit(xrst_n, 1'b1);
		t_traffic();
		@(negedge clk);
		fail = 1'b1;
		@(negedge clk);
		fail = 1'b0;
		cmp({29'h0, abrt, ready, busy}, 32'h4);
	endtask : t_power_entry
	////////////////////////////////
	initial
	begin
		{rst_n, start, mode, nopin, fail, rv, apndp, rnw, opt, addr, wdata, t_bad} = '0;
		t_ack = ACK_OK;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		entry(MODE_RESET, 1'b0);
		cmp(lo, 32'h8);
		cmp(po, 32'h0);
		cmp_bit(xrst_n, 1'b1);
		cmp_bit(pwr, 1'b1);
		t_traffic();
		t_fail_codes();
		t_power_entry();
		entry(MODE_RESET, 1'b1);
		cmp(lo, 32'h0);
		cmp(po, 32'h8);
		txn(4'h1, 32'hA5A5_0F0F, ACK_FAIL, 1'b0, 1'b0);
		rsp(1'b0, ACK_FAIL, 1'b0);
		tally_and_finish();
	end
	// the whole run needs well under 0.3 ms
	initial
	begin
		#1000000;
		err_total++;
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
